/* File: core/gex_pkg.sv */
package gex_pkg;

  localparam logic [2:0] CMD_IN_P0   = 3'h0;
  localparam logic [2:0] CMD_IN_P1   = 3'h1;
  localparam logic [2:0] CMD_OUT_P0  = 3'h2;
  localparam logic [2:0] CMD_OUT_P1  = 3'h3;
  localparam logic [2:0] CMD_INV_P0  = 3'h4;
  localparam logic [2:0] CMD_INV_P1  = 3'h5;
  localparam logic [2:0] CMD_DIR_P0  = 3'h6;
  localparam logic [2:0] CMD_DIR_P1  = 3'h7;

  localparam logic [7:0] RST_OUT     = 8'hff;
  localparam logic [7:0] RST_INV     = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'hff;

  // Upper five bits of the slave address; value is arbitrary
  localparam logic [4:0] ADDR_FIXED  = 5'h1a;

  localparam int         SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    GEX_IDLE  = 3'b000,
    GEX_ADDR  = 3'b001,
    GEX_AACK  = 3'b011,
    GEX_WRX   = 3'b010,
    GEX_WACK  = 3'b110,
    GEX_TX    = 3'b111,
    GEX_TACK  = 3'b101,
    GEX_SKIP  = 3'b100
  } gex_state_t;

  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p0;
  } gex_pair_t;

endpackage : gex_pkg

/* File: core/gex_top.sv */
module gex_top (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        reset_n,
  input  wire logic        addr_strap_lo,
  input  wire logic        addr_strap_hi,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe,
  output logic      [15:0] high_side_driver,
  output logic      [15:0] low_side_driver,
  output logic             int_out,
  output logic             int_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [1:0]  scl_s_r, sda_s_r, rstn_s_r, a0_s_r, a1_s_r;
  logic [15:0] pin_s1_r, pin_s2_r;
  logic        scl_d_r, sda_d_r;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s_r  <= 2'h3;
      sda_s_r  <= 2'h3;
      rstn_s_r <= 2'h0;
      a0_s_r   <= 2'h0;
      a1_s_r   <= 2'h0;
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_s_r  <= {scl_s_r[0], scl_in};
      sda_s_r  <= {sda_s_r[0], sda_in};
      rstn_s_r <= {rstn_s_r[0], reset_n};
      a0_s_r   <= {a0_s_r[0], addr_strap_lo};
      a1_s_r   <= {a1_s_r[0], addr_strap_hi};
      pin_s1_r <= pin_in;
      pin_s2_r <= pin_s1_r;
      scl_d_r  <= scl_s_r[1];
      sda_d_r  <= sda_s_r[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_det, stop_det, soft_rst;
  assign scl       = scl_s_r[1];
  assign sda       = sda_s_r[1];
  assign scl_rise  = scl & ~scl_d_r;
  assign scl_fall  = ~scl & scl_d_r;
  assign start_det = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_det  = scl & scl_d_r & ~sda_d_r & sda;
  assign soft_rst  = ~rstn_s_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine
  gex_pkg::gex_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [2:0] ptr_r;
  logic       rw_r, cmd_seen_r, sda_oe_r, nack_r;
  gex_pkg::gex_pair_t out_r, inv_r, dir_r, in_cap_r;

  logic [15:0] pin_val;
  assign pin_val = pin_s2_r ^ {inv_r.p1, inv_r.p0};

  function automatic logic [7:0] reg_read(input logic [2:0] p);
    unique case (p)
      gex_pkg::CMD_IN_P0:  reg_read = pin_val[7:0];
      gex_pkg::CMD_IN_P1:  reg_read = pin_val[15:8];
      gex_pkg::CMD_OUT_P0: reg_read = out_r.p0;
      gex_pkg::CMD_OUT_P1: reg_read = out_r.p1;
      gex_pkg::CMD_INV_P0: reg_read = inv_r.p0;
      gex_pkg::CMD_INV_P1: reg_read = inv_r.p1;
      gex_pkg::CMD_DIR_P0: reg_read = dir_r.p0;
      gex_pkg::CMD_DIR_P1: reg_read = dir_r.p1;
    endcase
  endfunction

  logic addr_match;
  assign addr_match = (shift_r[7:3] == gex_pkg::ADDR_FIXED) &&
                      (shift_r[2:1] == {a1_s_r[1], a0_s_r[1]});

  // Write strobe, one cycle, on the falling edge ending a data byte's acknowledge
  logic       wr_stb;
  logic [7:0] wr_data;
  logic       rd_p0_stb, rd_p1_stb;

  // Byte at the pointer and at its pair partner, for the transmit path
  logic [7:0] rd_cur_byte;
  logic [7:0] rd_alt_byte;
  always_comb begin
    rd_cur_byte = reg_read(ptr_r);
    rd_alt_byte = reg_read({ptr_r[2:1], ~ptr_r[0]});
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= gex_pkg::GEX_IDLE;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 4'h0;
      ptr_r      <= 3'h0;
      rw_r       <= 1'b0;
      cmd_seen_r <= 1'b0;
      sda_oe_r   <= 1'b0;
      nack_r     <= 1'b0;
    end else if (soft_rst || stop_det) begin
      state_r    <= gex_pkg::GEX_IDLE;
      bit_cnt_r  <= 4'h0;
      sda_oe_r   <= 1'b0;
      cmd_seen_r <= 1'b0;
      if (soft_rst) begin
        ptr_r <= 3'h0;
      end
    end else if (start_det) begin
      state_r    <= gex_pkg::GEX_ADDR;
      bit_cnt_r  <= 4'h0;
      sda_oe_r   <= 1'b0;
      cmd_seen_r <= 1'b0;
    end else begin
      if (scl_rise) begin
        if (state_r == gex_pkg::GEX_ADDR || state_r == gex_pkg::GEX_WRX) begin
          shift_r   <= {shift_r[6:0], sda};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (state_r == gex_pkg::GEX_TACK) begin
          nack_r <= sda;
        end
      end
      if (scl_fall) begin
        unique case (state_r)
          gex_pkg::GEX_ADDR: begin
            if (bit_cnt_r == 4'h8) begin
              if (addr_match) begin
                rw_r     <= shift_r[0];
                state_r  <= gex_pkg::GEX_AACK;
                sda_oe_r <= 1'b1;
              end else begin
                state_r  <= gex_pkg::GEX_SKIP;
              end
            end
          end
          gex_pkg::GEX_WRX: begin
            if (bit_cnt_r == 4'h8) begin
              state_r  <= gex_pkg::GEX_WACK;
              sda_oe_r <= 1'b1;
              if (!cmd_seen_r) begin
                ptr_r <= shift_r[2:0];
              end
            end
          end
          gex_pkg::GEX_AACK, gex_pkg::GEX_WACK: begin
            bit_cnt_r <= 4'h0;
            // The command byte's own acknowledge neither stores nor toggles
            if (state_r == gex_pkg::GEX_WACK) begin
              cmd_seen_r <= 1'b1;
              if (cmd_seen_r) begin
                ptr_r <= {ptr_r[2:1], ~ptr_r[0]};
              end
            end
            if (state_r == gex_pkg::GEX_AACK && rw_r) begin
              state_r  <= gex_pkg::GEX_TX;
              shift_r  <= {rd_cur_byte[6:0], 1'b0};
              sda_oe_r <= ~rd_cur_byte[7];
            end else begin
              state_r  <= gex_pkg::GEX_WRX;
              sda_oe_r <= 1'b0;
            end
          end
          gex_pkg::GEX_TX: begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'h7) begin
              state_r  <= gex_pkg::GEX_TACK;
              sda_oe_r <= 1'b0;
            end else begin
              sda_oe_r <= ~shift_r[7];
              shift_r  <= {shift_r[6:0], 1'b0};
            end
          end
          gex_pkg::GEX_TACK: begin
            bit_cnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= gex_pkg::GEX_SKIP;
            end else begin
              state_r  <= gex_pkg::GEX_TX;
              shift_r  <= {rd_alt_byte[6:0], 1'b0};
              sda_oe_r <= ~rd_alt_byte[7];
              ptr_r    <= {ptr_r[2:1], ~ptr_r[0]};
            end
          end
          gex_pkg::GEX_IDLE, gex_pkg::GEX_SKIP: begin
          end
        endcase
      end
    end
  end

  assign wr_stb  = scl_fall && state_r == gex_pkg::GEX_WACK && cmd_seen_r &&
                   !soft_rst && !stop_det && !start_det;
  assign wr_data = shift_r;
  // a read byte is loaded at the acknowledge falling edge; input port read
  assign rd_p0_stb = scl_fall && !soft_rst && !stop_det && !start_det &&
                     ((state_r == gex_pkg::GEX_AACK && rw_r) ||
                      (state_r == gex_pkg::GEX_TACK && !nack_r)) &&
                     (((state_r == gex_pkg::GEX_AACK) ? ptr_r
                       : {ptr_r[2:1], ~ptr_r[0]}) == gex_pkg::CMD_IN_P0);
  assign rd_p1_stb = scl_fall && !soft_rst && !stop_det && !start_det &&
                     ((state_r == gex_pkg::GEX_AACK && rw_r) ||
                      (state_r == gex_pkg::GEX_TACK && !nack_r)) &&
                     (((state_r == gex_pkg::GEX_AACK) ? ptr_r
                       : {ptr_r[2:1], ~ptr_r[0]}) == gex_pkg::CMD_IN_P1);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_r <= {gex_pkg::RST_OUT, gex_pkg::RST_OUT};
      inv_r <= {gex_pkg::RST_INV, gex_pkg::RST_INV};
      dir_r <= {gex_pkg::RST_DIR, gex_pkg::RST_DIR};
    end else if (soft_rst) begin
      out_r <= {gex_pkg::RST_OUT, gex_pkg::RST_OUT};
      inv_r <= {gex_pkg::RST_INV, gex_pkg::RST_INV};
      dir_r <= {gex_pkg::RST_DIR, gex_pkg::RST_DIR};
    end else if (wr_stb) begin
      unique case (ptr_r) // input port writes fall to no register
        gex_pkg::CMD_OUT_P0: out_r.p0 <= wr_data;
        gex_pkg::CMD_OUT_P1: out_r.p1 <= wr_data;
        gex_pkg::CMD_INV_P0: inv_r.p0 <= wr_data;
        gex_pkg::CMD_INV_P1: inv_r.p1 <= wr_data;
        gex_pkg::CMD_DIR_P0: dir_r.p0 <= wr_data;
        gex_pkg::CMD_DIR_P1: dir_r.p1 <= wr_data;
        gex_pkg::CMD_IN_P0, gex_pkg::CMD_IN_P1: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: captured value per port, re-armed by that port's read
  logic       cap_init_r;
  logic [1:0] chg;
  logic [15:0] in_mask;
  assign in_mask = {dir_r.p1, dir_r.p0};
  assign chg[0]  = |((pin_val[7:0] ^ in_cap_r.p0) & in_mask[7:0]);
  assign chg[1]  = |((pin_val[15:8] ^ in_cap_r.p1) & in_mask[15:8]);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_cap_r   <= 16'h0000;
      cap_init_r <= 1'b0;
    end else if (soft_rst || !cap_init_r) begin
      in_cap_r   <= pin_val;
      cap_init_r <= ~soft_rst;
    end else begin
      if (rd_p0_stb) begin
        in_cap_r.p0 <= pin_val[7:0];
      end
      if (rd_p1_stb) begin
        in_cap_r.p1 <= pin_val[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sda_out          <= 1'b0;
      sda_oe           <= 1'b0;
      pin_out          <= 16'h0000;
      pin_oe           <= 16'h0000;
      high_side_driver <= 16'h0000;
      low_side_driver  <= 16'h0000;
      int_out          <= 1'b0;
      int_oe           <= 1'b0;
    end else begin
      sda_out          <= 1'b0;
      sda_oe           <= sda_oe_r;
      pin_out          <= {out_r.p1, out_r.p0};
      pin_oe           <= ~in_mask;
      high_side_driver <= ~in_mask & {out_r.p1, out_r.p0};
      low_side_driver  <= ~in_mask & ~{out_r.p1, out_r.p0};
      int_out          <= 1'b0;
      int_oe           <= cap_init_r && !soft_rst && (|chg);
    end
  end

endmodule // gex_top

/* File: sim/gex_sva.sv */
module gex_sva (
  input logic        ref_clk,
  input logic        sys_rst,
  input logic        reset_n,
  input logic        addr_strap_lo,
  input logic        addr_strap_hi,
  input logic        scl_in,
  input logic        sda_in,
  input logic        sda_out,
  input logic        sda_oe,
  input logic [15:0] pin_in,
  input logic [15:0] pin_out,
  input logic [15:0] pin_oe,
  input logic [15:0] high_side_driver,
  input logic [15:0] low_side_driver,
  input logic        int_out,
  input logic        int_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  a_drv_split: assert property (
    high_side_driver == (pin_oe & pin_out) && low_side_driver == (pin_oe & ~pin_out))
    else $error("driver enables disagree with direction and level");
  a_open_drain: assert property (sda_out == 1'b0 && int_out == 1'b0)
    else $error("open-drain data level not low");
  a_por_default: assert property (
    $fell(sys_rst) |-> ##2 (pin_oe == 16'h0000 && pin_out == 16'hffff && !int_oe))
    else $error("defaults missing after power-up reset");
  a_pin_reset: assert property (
    $fell(reset_n) |-> ##[1:5] (pin_oe == 16'h0000 && pin_out == 16'hffff && !int_oe))
    else $error("defaults missing under reset pin");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("pull on data released too early");
  a_stop_idle: assert property (scl_in && $rose(sda_in) |-> !sda_oe [*8])
    else $error("data pulled after stop");
  a_int_cause: assert property ($rose(int_oe) |-> pin_in != $past(pin_in, 8))
    else $error("interrupt without pin change");
endmodule // gex_sva

bind gex_top gex_sva u_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reset_n(reset_n),
  .addr_strap_lo(addr_strap_lo), .addr_strap_hi(addr_strap_hi),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .high_side_driver(high_side_driver), .low_side_driver(low_side_driver),
  .int_out(int_out), .int_oe(int_oe)
);

/* File: sim/gex_i2c_master.sv */
module gex_i2c_master (
  output logic scl,
  output logic sda_pull,
  input  logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves only in SCL low, well clear of the fall
  task automatic bit_io(input logic b, output logic s);
    #45 sda_pull = ~b;
    #17 scl = 1'b1;
    #55 s = sda;
    #8 scl = 1'b0;
  endtask
  task automatic start();
    #45 sda_pull = 1'b0;
    #17 scl = 1'b1;
    #30 sda_pull = 1'b1;
    #30 scl = 1'b0;
  endtask
  task automatic stop();
    #45 sda_pull = 1'b1;
    #17 scl = 1'b1;
    #30 sda_pull = 1'b0;
    #60;
  endtask
  task automatic wbyte(input logic [7:0] d, inout logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ok &= ~s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
  task automatic wr(input logic [6:0] a, input logic [2:0] c,
                    input logic [7:0] d [4], input int n, output logic ok);
    ok = 1'b1;
    start();
    wbyte({a, 1'b0}, ok);
    wbyte({5'h00, c}, ok);
    for (int i = 0; i < n; i++) wbyte(d[i], ok);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [2:0] c, input int n,
                    output logic [15:0] q, output logic ok);
    ok = 1'b1;
    q  = 16'h0000;
    start();
    wbyte({a, 1'b0}, ok);
    wbyte({5'h00, c}, ok);
    start();
    wbyte({a, 1'b1}, ok);
    rbyte(n == 1, q[15:8]);
    if (n > 1) rbyte(1'b1, q[7:0]);
    stop();
  endtask
endmodule // gex_i2c_master

/* File: sim/test_gex_top.sv */
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module test_gex_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = {gex_pkg::ADDR_FIXED, 2'b10};
  logic        ref_clk;
  logic        sys_rst;
  logic        reset_n;
  logic        scl;
  logic        m_pull;
  logic        sda_out;
  logic        sda_oe;
  logic        int_out;
  logic        int_oe;
  logic        ok;
  logic [15:0] ext;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] hi_drv;
  logic [15:0] lo_drv;
  logic [15:0] q;
  int          fails = 0;
  int          n_tests = 0;
  wire         sda_wire = ~(m_pull | (sda_oe & ~sda_out));
  wire  [15:0] pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);
  wire         int_n_line = ~(int_oe & ~int_out);
  gex_top uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reset_n(reset_n),
    .addr_strap_lo(1'b0), .addr_strap_hi(1'b1), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .high_side_driver(hi_drv), .low_side_driver(lo_drv),
    .int_out(int_out), .int_oe(int_oe)
  );
  gex_i2c_master m (.scl(scl), .sda_pull(m_pull), .sda(sda_wire));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic set_ext(input logic [15:0] v);
    wait_clk(1);
    ext = v;
    wait_clk(8);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic t_defaults();
    `CHK(pin_oe, 16'h0000)
    `CHK(hi_drv | lo_drv, 16'h0000)
    m.rd(DEV, gex_pkg::CMD_OUT_P0, 2, q, ok);
    `CHK({ok, q}, {1'b1, gex_pkg::RST_OUT, gex_pkg::RST_OUT})
    m.rd(DEV, gex_pkg::CMD_INV_P1, 2, q, ok);
    `CHK({ok, q}, {1'b1, gex_pkg::RST_INV, gex_pkg::RST_INV})
    m.rd(DEV, gex_pkg::CMD_DIR_P0, 2, q, ok);
    `CHK({ok, q}, {1'b1, gex_pkg::RST_DIR, gex_pkg::RST_DIR})
    $display("t_defaults finished");
  endtask
  task automatic t_write();
    m.wr(DEV, gex_pkg::CMD_OUT_P1, '{8'ha5, 8'h3c, 8'h0f, 8'h00}, 3, ok);
    `CHK(ok, 1'b1)
    m.wr(DEV, gex_pkg::CMD_DIR_P0, '{8'h00, 8'h0f, 8'h00, 8'h00}, 2, ok);
    wait_clk(4);
    `CHK(pin_out, 16'h0f3c)
    `CHK(pin_oe, 16'hf0ff)
    `CHK(hi_drv, 16'h003c)
    `CHK(lo_drv, 16'hf0c3)
    // Port 1 pins 11:8 read back 4'ha, so flop and pin differ
    m.rd(DEV, gex_pkg::CMD_OUT_P1, 2, q, ok);
    `CHK(q, 16'h0f3c)
    `CHK(sda_wire, 1'b1)
    $display("t_write finished");
  endtask
  task automatic t_inputs();
    m.wr(DEV, gex_pkg::CMD_INV_P1, '{8'hf0, 8'h00, 8'h00, 8'h00}, 1, ok);
    m.wr(DEV, gex_pkg::CMD_IN_P0, '{8'h00, 8'h00, 8'h00, 8'h00}, 2, ok);
    `CHK(ok, 1'b1)
    m.rd(DEV, gex_pkg::CMD_IN_P1, 2, q, ok);
    `CHK(q, 16'hfa3c)
    $display("t_inputs finished");
  endtask
  task automatic t_irq();
    `CHK(int_oe, 1'b0)
    set_ext(16'h5b00);
    `CHK(int_oe, 1'b1)
    `CHK(int_n_line, 1'b0)
    m.rd(DEV, gex_pkg::CMD_IN_P0, 1, q, ok);
    `CHK(int_oe, 1'b1)
    m.rd(DEV, gex_pkg::CMD_IN_P1, 1, q, ok);
    `CHK(q[15:8], 8'hfb)
    `CHK(int_oe, 1'b0)
    set_ext(16'h5900);
    `CHK(int_oe, 1'b1)
    set_ext(16'h5b00);
    `CHK(int_oe, 1'b0)
    m.wr(DEV, gex_pkg::CMD_OUT_P0, '{8'hc3, 8'h00, 8'h00, 8'h00}, 1, ok);
    wait_clk(8);
    `CHK(int_oe, 1'b0)
    $display("t_irq finished");
  endtask
  task automatic t_abort();
    m.wr(DEV ^ 7'h01, gex_pkg::CMD_OUT_P0, '{8'h00, 8'h00, 8'h00, 8'h00}, 1, ok);
    `CHK(ok, 1'b0)
    ok = 1'b1;
    m.start();
    m.wbyte({DEV, 1'b0}, ok);
    m.wbyte({5'h00, gex_pkg::CMD_OUT_P0}, ok);
    for (int i = 0; i < 4; i++) m.bit_io(1'b0, ok);
    m.stop();
    wait_clk(2);
    `CHK(pin_out, 16'h0fc3)
    m.rd(DEV, gex_pkg::CMD_OUT_P1, 2, q, ok);
    `CHK({ok, q}, {1'b1, 16'h0fc3})
    $display("t_abort finished");
  endtask
  task automatic t_reset_pin();
    wait_clk(1);
    reset_n = 1'b0;
    wait_clk(5);
    `CHK(pin_oe, 16'h0000)
    `CHK(pin_out, 16'hffff)
    reset_n = 1'b1;
    wait_clk(10);
    m.rd(DEV, gex_pkg::CMD_DIR_P1, 2, q, ok);
    `CHK({ok, q}, {1'b1, gex_pkg::RST_DIR, gex_pkg::RST_DIR})
    $display("t_reset_pin finished");
  endtask
  initial begin
    sys_rst = 1'b1;
    reset_n = 1'b1;
    ext     = 16'h5a00;
    wait_clk(3);
    sys_rst = 1'b0;
    wait_clk(12);
    t_defaults();
    t_write();
    t_inputs();
    t_irq();
    t_abort();
    t_reset_pin();
    complete_run();
  end
  initial begin
    #600_000;
    fails++;
    complete_run();
  end
endmodule // test_gex_top
